// ### gcos_pkg.sv
// Behaviour
// - Low reset input resets all logic
// - Enable input high forces overcurrent gate levels
// - High-side polarity pin sets high-side active level
// - Low-side polarity pin sets low-side active level
// - Overcurrent drives high sides to given level
// - Overcurrent drives low sides to given level
// - High on active-high trip input means overcurrent
// - Low on active-low trip input means overcurrent
// - Status output high during overcurrent, one clock cycle late
// - Scheme select low two-phase, high three-phase
// - Three-phase holds bridge one high side inactive
// - Three-phase holds bridge one low side inactive
// - Bridges map Y2,Y1,X2,X1 or -,W,V,U
package gcos_pkg;

	localparam int APB_AW = 8;
	localparam int APB_DW = 32;
	localparam int NUM_BRIDGES = 4;
	localparam int DEAD_W = 8;

	// Register byte offsets
	localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] OFS_DEAD = 8'h04;
	localparam logic [APB_AW-1:0] OFS_STATUS = 8'h08;
	localparam logic [APB_AW-1:0] OFS_MASK = 8'h0C;
	localparam logic [APB_AW-1:0] OFS_STATE = 8'h10;

	// Control register fields
	localparam int CTRL_FORCE_BIT = 0;
	localparam int CTRL_W = 1;
	localparam logic [CTRL_W-1:0] CTRL_RST = 1'h0;

	// Break-before-make gap in clock cycles, less one
	localparam logic [DEAD_W-1:0] DEAD_RST = 8'h10;

	// Event bits, shared by status and mask
	localparam int EVT_OC_BIT = 0;
	localparam int EVT_DIS_BIT = 1;
	localparam int EVT_W = 2;
	localparam logic [EVT_W-1:0] EVT_RST = 2'h0;

	// Live state register fields
	localparam int ST_OC_BIT = 0;
	localparam int ST_EN_N_BIT = 1;
	localparam int ST_SCHEME_BIT = 2;
	localparam int ST_SAFE_BIT = 3;
	localparam int ST_HS_LSB = 4;
	localparam int ST_LS_LSB = 8;

	// Phase demand per bridge, bit index = bridge number minus one
	typedef struct packed {
		logic x1_u;
		logic x2_v;
		logic y1_w;
		logic y2;
	} gcos_demand_t;

	// Logical gate activity, before polarity is applied
	typedef struct packed {
		logic [NUM_BRIDGES-1:0] high;
		logic [NUM_BRIDGES-1:0] low;
	} gcos_gates_t;

	typedef enum logic [1:0] {
		GCOS_OFF,
		GCOS_LOW,
		GCOS_HIGH
	} gcos_bbm_state_t;

endpackage : gcos_pkg

// ### gcos_bbm.sv
module gcos_bbm import gcos_pkg::*; #(
	parameter int DW = DEAD_W
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic demand, // 1 = high side on, 0 = low side on
	input wire logic hold_off, // Keep both sides off
	input wire logic [DW-1:0] dead_cycles, // Gap length minus one, in cycles
	output logic hs_on, // High side active
	output logic ls_on // Low side active
);

	gcos_bbm_state_t state;
	gcos_bbm_state_t next_state;
	logic [DW-1:0] cnt;
	logic [DW-1:0] next_cnt;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			GCOS_LOW: begin
				if (hold_off || demand) begin
					next_state = GCOS_OFF;
					next_cnt = dead_cycles;
				end
			end
			GCOS_HIGH: begin
				if (hold_off || !demand) begin
					next_state = GCOS_OFF;
					next_cnt = dead_cycles;
				end
			end
			GCOS_OFF: begin
				if (hold_off) begin
					next_cnt = dead_cycles;
				end else if (cnt == '0) begin
					next_state = demand ? GCOS_HIGH : GCOS_LOW;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			default: begin
				next_state = GCOS_OFF;
				next_cnt = dead_cycles;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= GCOS_OFF;
			cnt <= DW'(DEAD_RST);
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	assign hs_on = (state == GCOS_HIGH);
	assign ls_on = (state == GCOS_LOW);

endmodule : gcos_bbm

// ### gcos_top.sv
module gcos_top import gcos_pkg::*; (
	input wire logic pclk, // System clock, 100 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic [APB_AW-1:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction, 1 = write
	input wire logic [APB_DW-1:0] pwdata, // APB write data
	output logic [APB_DW-1:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire gcos_demand_t phase_demand, // Per-bridge phase demand
	input wire logic gate_enable_n, // Gate enable, active low
	input wire logic hs_polarity, // High-side active level
	input wire logic ls_polarity, // Low-side active level
	input wire logic oc_high_side_level, // High-side level when safe
	input wire logic oc_low_side_level, // Low-side level when safe
	input wire logic oc_trip_hi, // Trip input, high = fault
	input wire logic oc_trip_lo, // Trip input, low = fault
	input wire logic motor_scheme_sel, // 0 two-phase, 1 three-phase
	output logic bridge1_high_gate, // Bridge 1 high-side gate
	output logic bridge1_low_gate, // Bridge 1 low-side gate
	output logic bridge2_high_gate, // Bridge 2 high-side gate
	output logic bridge2_low_gate, // Bridge 2 low-side gate
	output logic bridge3_high_gate, // Bridge 3 high-side gate
	output logic bridge3_low_gate, // Bridge 3 low-side gate
	output logic bridge4_high_gate, // Bridge 4 high-side gate
	output logic bridge4_low_gate, // Bridge 4 low-side gate
	output logic overcurrent_flag, // Overcurrent status
	output logic irq // Interrupt, level, active high
);

	// Register state
	logic [CTRL_W-1:0] ctrl;
	logic [CTRL_W-1:0] next_ctrl;
	logic [DEAD_W-1:0] dead;
	logic [DEAD_W-1:0] next_dead;
	logic [EVT_W-1:0] status;
	logic [EVT_W-1:0] next_status;
	logic [EVT_W-1:0] mask;
	logic [EVT_W-1:0] next_mask;
	logic [APB_DW-1:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_irq;

	// Event detection state
	logic oc_prev;
	logic en_n_prev;
	logic next_oc_prev;
	logic next_en_n_prev;

	// Gate output state
	logic [NUM_BRIDGES-1:0] high_pin;
	logic [NUM_BRIDGES-1:0] low_pin;
	logic [NUM_BRIDGES-1:0] next_high_pin;
	logic [NUM_BRIDGES-1:0] next_low_pin;
	logic next_oc_flag;

	logic oc_now;
	logic safe;
	logic wr_access;
	logic setup;
	logic [NUM_BRIDGES-1:0] demand_vec;
	logic [NUM_BRIDGES-1:0] hold_vec;
	gcos_gates_t act;
	logic [EVT_W-1:0] events;

	function automatic logic addr_mapped(input logic [APB_AW-1:0] a);
		addr_mapped = (a == OFS_CTRL) || (a == OFS_DEAD) ||
			(a == OFS_STATUS) || (a == OFS_MASK) || (a == OFS_STATE);
	endfunction : addr_mapped

	// Either trip input alone is enough
	assign oc_now = oc_trip_hi || !oc_trip_lo;
	assign safe = oc_now || gate_enable_n || ctrl[CTRL_FORCE_BIT];
	assign setup = psel && !penable;
	assign wr_access = psel && penable && pready && pwrite;
	assign demand_vec = phase_demand;

	// Bridge sequencers
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BRIDGES; gi++) begin : g_bridge
			if (gi == 0) begin : g_first
				assign hold_vec[gi] = safe || motor_scheme_sel;
			end else begin : g_rest
				assign hold_vec[gi] = safe;
			end
			gcos_bbm #(
				.DW(DEAD_W)
			) u_bbm (
				.pclk(pclk),
				.presetn(presetn),
				.demand(demand_vec[gi]),
				.hold_off(hold_vec[gi]),
				.dead_cycles(dead),
				.hs_on(act.high[gi]),
				.ls_on(act.low[gi])
			);
		end
	endgenerate

	// Gate levels: safe levels win over everything
	always_comb begin
		for (int i = 0; i < NUM_BRIDGES; i++) begin
			if (safe) begin
				next_high_pin[i] = oc_high_side_level;
				next_low_pin[i] = oc_low_side_level;
			end else begin
				next_high_pin[i] = act.high[i] ? hs_polarity : !hs_polarity;
				next_low_pin[i] = act.low[i] ? ls_polarity : !ls_polarity;
			end
		end
		next_oc_flag = oc_now;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_pin <= '0;
			low_pin <= '0;
			overcurrent_flag <= 1'b0;
		end else begin
			high_pin <= next_high_pin;
			low_pin <= next_low_pin;
			overcurrent_flag <= next_oc_flag;
		end
	end

	assign bridge1_high_gate = high_pin[0];
	assign bridge2_high_gate = high_pin[1];
	assign bridge3_high_gate = high_pin[2];
	assign bridge4_high_gate = high_pin[3];
	assign bridge1_low_gate = low_pin[0];
	assign bridge2_low_gate = low_pin[1];
	assign bridge3_low_gate = low_pin[2];
	assign bridge4_low_gate = low_pin[3];

	// Events: overcurrent onset and enable release
	always_comb begin
		next_oc_prev = oc_now;
		next_en_n_prev = gate_enable_n;
		events = '0;
		events[EVT_OC_BIT] = oc_now && !oc_prev;
		events[EVT_DIS_BIT] = gate_enable_n && !en_n_prev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oc_prev <= 1'b0;
			en_n_prev <= 1'b0;
		end else begin
			oc_prev <= next_oc_prev;
			en_n_prev <= next_en_n_prev;
		end
	end

	// Register writes; a new event beats a same-cycle clear
	always_comb begin
		next_ctrl = ctrl;
		next_dead = dead;
		next_mask = mask;
		next_status = status;
		if (wr_access) begin
			case (paddr)
				OFS_CTRL: next_ctrl = pwdata[CTRL_W-1:0];
				OFS_DEAD: next_dead = pwdata[DEAD_W-1:0];
				OFS_MASK: next_mask = pwdata[EVT_W-1:0];
				OFS_STATUS: next_status = status & ~pwdata[EVT_W-1:0];
				default: next_status = status;
			endcase
		end
		next_status = next_status | events;
		next_irq = |(next_status & next_mask);
	end

	// Read data and answer are prepared in the setup cycle
	always_comb begin
		next_prdata = '0;
		next_pready = setup;
		next_pslverr = setup && !addr_mapped(paddr);
		if (setup && !pwrite) begin
			case (paddr)
				OFS_CTRL: next_prdata[CTRL_W-1:0] = ctrl;
				OFS_DEAD: next_prdata[DEAD_W-1:0] = dead;
				OFS_STATUS: next_prdata[EVT_W-1:0] = status;
				OFS_MASK: next_prdata[EVT_W-1:0] = mask;
				OFS_STATE: begin
					next_prdata[ST_OC_BIT] = oc_now;
					next_prdata[ST_EN_N_BIT] = gate_enable_n;
					next_prdata[ST_SCHEME_BIT] = motor_scheme_sel;
					next_prdata[ST_SAFE_BIT] = safe;
					next_prdata[ST_HS_LSB +: NUM_BRIDGES] = act.high;
					next_prdata[ST_LS_LSB +: NUM_BRIDGES] = act.low;
				end
				default: next_prdata = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RST;
			dead <= DEAD_RST;
			status <= EVT_RST;
			mask <= EVT_RST;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			dead <= next_dead;
			status <= next_status;
			mask <= next_mask;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			irq <= next_irq;
		end
	end

endmodule : gcos_top

// ### gcos_sva.sv
module gcos_sva (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic gate_enable_n, // Enable
	input wire logic hs_polarity, // Polarity
	input wire logic ls_polarity, // Polarity
	input wire logic oc_high_side_level, // Safe level
	input wire logic oc_low_side_level, // Safe level
	input wire logic oc_trip_hi, // Trip
	input wire logic oc_trip_lo, // Trip
	input wire logic motor_scheme_sel, // Scheme
	input wire logic bridge1_high_gate, // Gate
	input wire logic bridge1_low_gate, // Gate
	input wire logic bridge2_high_gate, // Gate
	input wire logic bridge2_low_gate, // Gate
	input wire logic bridge3_high_gate, // Gate
	input wire logic bridge3_low_gate, // Gate
	input wire logic bridge4_high_gate, // Gate
	input wire logic bridge4_low_gate, // Gate
	input wire logic overcurrent_flag // Flag
);
	timeunit 1ns;
	timeprecision 100ps;
	logic trip, safe, shoot;
	logic [3:0] hg, lg;
	assign trip = oc_trip_hi | ~oc_trip_lo;
	assign safe = trip | gate_enable_n;
	assign hg = {bridge4_high_gate, bridge3_high_gate,
		bridge2_high_gate, bridge1_high_gate};
	assign lg = {bridge4_low_gate, bridge3_low_gate,
		bridge2_low_gate, bridge1_low_gate};
	// Some bridge has both sides active
	assign shoot = |((hg ~^ {4{hs_polarity}}) & (lg ~^ {4{ls_polarity}}));
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Antecedents need reset sampled off: outputs lag release by an edge
	a_trip_flag: assert property (presetn && trip
		|=> overcurrent_flag)
		else $error("No flag on trip");
	a_flag_clear: assert property (presetn && !trip
		|=> !overcurrent_flag)
		else $error("Flag without trip");
	a_enable_safe: assert property (presetn && gate_enable_n |=>
		hg == {4{$past(oc_high_side_level)}}
		&& lg == {4{$past(oc_low_side_level)}})
		else $error("Disabled gates not safe");
	a_trip_high: assert property (presetn && trip |=>
		hg == {4{$past(oc_high_side_level)}})
		else $error("High sides not safe");
	a_trip_low: assert property (presetn && trip |=>
		lg == {4{$past(oc_low_side_level)}})
		else $error("Low sides not safe");
	a_tri_bridge1: assert property (
		presetn && motor_scheme_sel && !safe
		|=> bridge1_high_gate == !$past(hs_polarity)
		&& bridge1_low_gate == !$past(ls_polarity))
		else $error("Bridge one active in three-phase");
	a_no_shoot: assert property ($past(presetn) && !$past(safe)
		&& $stable(hs_polarity) && $stable(ls_polarity) |-> !shoot)
		else $error("Both sides active");
	// Bridge two low side turning on needs the high side off one cycle before
	a_bbm_gap: assert property ($past(presetn, 2)
		&& !$past(safe) && !$past(safe, 2)
		&& $stable(hs_polarity) && $stable(ls_polarity)
		&& $past(hs_polarity, 2) == hs_polarity
		&& $past(ls_polarity, 2) == ls_polarity
		&& $rose(bridge2_low_gate ~^ ls_polarity)
		|-> bridge2_high_gate != hs_polarity
		&& $past(bridge2_high_gate != hs_polarity))
		else $error("No gap before low side on");
endmodule : gcos_sva

bind gcos_top gcos_sva sva_u (.*);

// ### gcos_drv_model.sv
module gcos_drv_model (
	input wire logic [7:0] gates, // Pins, bridge 4 high first
	input wire logic hs_polarity, // High-side active level
	input wire logic ls_polarity, // Low-side active level
	input wire logic [1:0] fault, // Injected fault per comparator
	output logic oc_trip_hi, // Comparator, high on fault
	output logic oc_trip_lo // Comparator, low on fault
);
	timeunit 1ns;
	timeprecision 100ps;
	logic short_ckt;
	// Bridge shorted when both sides are on
	always_comb begin
		short_ckt = 1'h0;
		for (int i = 0; i < 4; i++) begin
			short_ckt |= gates[2*i+1] == hs_polarity && gates[2*i] == ls_polarity;
		end
	end
	assign oc_trip_hi = fault[0] | short_ckt;
	assign oc_trip_lo = ~(fault[1] | short_ckt);
endmodule : gcos_drv_model

// ### test_gate_control_output_stage.sv
module test_gate_control_output_stage import gcos_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, pready, pslverr, irq, overcurrent_flag;
	logic [APB_AW-1:0] paddr = '0;
	logic [APB_DW-1:0] pwdata = '0, prdata;
	gcos_demand_t phase_demand = '0;
	logic gate_enable_n = 1'h0, hs_polarity = 1'h1, ls_polarity = 1'h1;
	logic oc_high_side_level = 1'h0, oc_low_side_level = 1'h0;
	logic motor_scheme_sel = 1'h0, oc_trip_hi, oc_trip_lo;
	logic bridge1_high_gate, bridge1_low_gate, bridge2_high_gate;
	logic bridge2_low_gate, bridge3_high_gate, bridge3_low_gate;
	logic bridge4_high_gate, bridge4_low_gate;
	logic [1:0] fault = 2'h0;
	logic [7:0] gates;
	int fails = 0, compares = 0, cyc = 0;
	assign gates = {bridge4_high_gate, bridge4_low_gate, bridge3_high_gate,
		bridge3_low_gate, bridge2_high_gate, bridge2_low_gate,
		bridge1_high_gate, bridge1_low_gate};
	gcos_top dut_u (.*);
	gcos_drv_model far_u (.*);
	always #5 pclk = ~pclk;
	task automatic tally_and_finish();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails = fails + 1;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt
	// One transfer; compares {pslverr, read data}
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] e);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		chk({pslverr, w ? 32'h0 : prdata}, e);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// Reconfigure while disabled, then flip demand live
	task automatic cfg(input logic [2:0] k, input logic [3:0] dm);
		logic [7:0] e;
		for (int i = 0; i < 4; i++) begin
			e[2*i+1] = dm[i] ~^ k[0];
			e[2*i] = dm[i] ^ k[1];
		end
		if (k[2]) e[1:0] = ~{k[0], k[1]};
		gate_enable_n <= 1'h1;
		oc_high_side_level <= ~k[0];
		oc_low_side_level <= ~k[1];
		hs_polarity <= k[0];
		ls_polarity <= k[1];
		motor_scheme_sel <= k[2];
		wt(4);
		gate_enable_n <= 1'h0;
		wt(20);
		phase_demand <= dm;
		wt(20);
		chk(33'(gates), 33'(e));
		chk(33'(overcurrent_flag), '0);
	endtask : cfg
	initial begin
		wt(12);
		presetn <= 1'h1;
		apb(1'h0, OFS_DEAD, '0, 33'h10);
		apb(1'h0, OFS_MASK, '0, '0);
		apb(1'h0, 8'h14, '0, 33'h100000000);
		apb(1'h1, OFS_DEAD, '0, '0);
		apb(1'h1, OFS_MASK, 32'h3, '0);
		for (int k = 0; k < 8; k++) cfg(3'(k), 4'h5 ^ {4{k[0]}});
		apb(1'h1, OFS_DEAD, 32'h3, '0);
		phase_demand <= 4'h8;
		// Gap of three plus one cycles keeps bridge two low side off
		wt(5);
		chk(33'(gates[3:2]), '0);
		wt(2);
		chk(33'(gates[3:2]), 33'h1);
		apb(1'h1, OFS_CTRL, 32'h1, '0);
		wt(2);
		chk(33'(gates), '0);
		apb(1'h0, OFS_STATE, '0, 33'hC);
		apb(1'h0, OFS_CTRL, '0, 33'h1);
		apb(1'h1, OFS_CTRL, '0, '0);
		apb(1'h1, OFS_STATUS, 32'h3, '0);
		for (int c = 0; c < 3; c++) begin
			fault <= 2'(1 << c);
			gate_enable_n <= c == 2;
			oc_high_side_level <= c[0];
			oc_low_side_level <= !c[0];
			wt(3);
			chk(33'(gates), 33'({4{c[0], !c[0]}}));
			chk({overcurrent_flag, irq}, {31'h0, c < 2, 1'h1});
			apb(1'h0, OFS_STATUS, '0, c < 2 ? 33'h1 : 33'h2);
			fault <= 2'h0;
			gate_enable_n <= 1'h0;
			apb(1'h1, OFS_STATUS, 32'h3, '0);
			wt(2);
			chk({overcurrent_flag, irq}, '0);
		end
		apb(1'h1, OFS_MASK, '0, '0);
		gate_enable_n <= 1'h1;
		apb(1'h0, OFS_STATUS, '0, 33'h2);
		chk(33'(irq), '0);
		presetn <= 1'h0;
		wt(2);
		presetn <= 1'h1;
		apb(1'h0, OFS_DEAD, '0, 33'h10);
		tally_and_finish();
	end
endmodule : test_gate_control_output_stage
